// [logic/pin_mux_pkg.sv]
package pin_mux_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses, 32-bit words)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h14;
	localparam logic [7:0] STAT_OFS = 8'h18;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] RD_NONE = 32'h0000_0000;

	// ---------------------------------------------------------------
	// control field positions
	// ---------------------------------------------------------------
	localparam int EN_BIT = 0;
	localparam int VAL_BIT = 1;
	localparam int SRC_LSB = 2;
	localparam int SEL_LSB = 5;

	// ---------------------------------------------------------------
	// status field positions
	// ---------------------------------------------------------------
	localparam int ST_LEVEL_BIT = 0;
	localparam int ST_EN_BIT = 1;
	localparam int ST_PIN_BIT = 2;
	localparam int ST_RSVD_BIT = 3;

	// ---------------------------------------------------------------
	// source group and selection codes
	// ---------------------------------------------------------------
	localparam int RX_PORTS = 4;
	localparam int TX_PORTS = 2;
	localparam logic [2:0] SRC_DEV = 3'h4;
	localparam logic [2:0] SRC_RSVD = 3'h5;
	localparam logic [2:0] SEL_RX_LOCK = 3'h4;
	localparam logic [2:0] SEL_RX_LV = 3'h7;
	localparam logic [2:0] SEL_DEV_REG = 3'h0;
	localparam logic [2:0] SEL_DEV_LOCK_OR = 3'h1;
	localparam logic [2:0] SEL_DEV_LOCK_AND = 3'h2;
	localparam logic [2:0] SEL_DEV_FSYNC = 3'h4;
	localparam logic [2:0] SEL_DEV_RSVD = 3'h5;
	localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
	localparam logic [2:0] SEL_TX_IRQ = 3'h5;
endpackage : pin_mux_pkg

// [logic/pin_sel_if.sv]
`timescale 1ns/1ps
interface pin_sel_if;
	logic [2:0] src;
	logic [2:0] sel;
	logic reg_level;
	logic level;
	logic reserved;

	modport ctrl (output src, output sel, output reg_level,
		input level, input reserved);
	modport mux (input src, input sel, input reg_level,
		output level, output reserved);
endinterface : pin_sel_if

// [logic/pin_source_mux.sv]
`timescale 1ns/1ps
module pin_source_mux
	import pin_mux_pkg::*;
(
	pin_sel_if.mux sel_bus,
	input wire logic [15:0] rx_remote_pin_i,
	input wire logic [3:0] rx_lock_i,
	input wire logic [3:0] rx_pass_i,
	input wire logic [3:0] rx_fv_i,
	input wire logic [3:0] rx_lv_i,
	input wire logic [3:0] rx_port_en_i,
	input wire logic frame_sync_signal_i,
	input wire logic [7:0] tx_rx_mask_i,
	input wire logic [1:0] tx_fv_i,
	input wire logic [1:0] tx_lv_i,
	input wire logic [1:0] tx_sync_i,
	input wire logic [1:0] tx_irq_i
);
	logic [7:0] rx_bundle [RX_PORTS];
	logic [7:0] tx_bundle [TX_PORTS];
	logic [7:0] dev_bundle;
	logic lock_or_en;
	logic lock_and_en;
	logic pass_and_en;
	logic rx_level;
	logic tx_level;
	logic dev_level;
	logic src_rsvd;
	logic sel_rsvd;

	// ---------------------------------------------------------------
	// per-port signal bundles, indexed by the selection code
	// ---------------------------------------------------------------
	for (genvar p = 0; p < RX_PORTS; p++) begin : g_rx
		assign rx_bundle[p] = {rx_lv_i[p], rx_fv_i[p], rx_pass_i[p],
			rx_lock_i[p], rx_remote_pin_i[4*p +: 4]};
	end

	// an empty mask would make the AND vacuously true; force it low
	for (genvar t = 0; t < TX_PORTS; t++) begin : g_tx
		logic [3:0] m;
		assign m = tx_rx_mask_i[4*t +: 4];
		assign tx_bundle[t] = {2'b00, tx_irq_i[t], tx_sync_i[t],
			tx_lv_i[t], tx_fv_i[t], |(rx_pass_i & m),
			(|m) & (&(rx_pass_i | ~m))};
	end

	// ---------------------------------------------------------------
	// device status group
	// ---------------------------------------------------------------
	assign lock_or_en = |(rx_lock_i & rx_port_en_i);
	assign lock_and_en = (|rx_port_en_i)
		& (&(rx_lock_i | ~rx_port_en_i));
	assign pass_and_en = (|rx_port_en_i)
		& (&(rx_pass_i | ~rx_port_en_i));
	assign dev_bundle = {3'h0, frame_sync_signal_i, pass_and_en,
		lock_and_en, lock_or_en, sel_bus.reg_level};

	// ---------------------------------------------------------------
	// group and signal selection
	// ---------------------------------------------------------------
	assign rx_level = rx_bundle[sel_bus.src[1:0]][sel_bus.sel];
	assign tx_level = tx_bundle[sel_bus.src[0]][sel_bus.sel];
	assign dev_level = dev_bundle[sel_bus.sel];
	assign src_rsvd = (sel_bus.src == SRC_RSVD);
	assign sel_rsvd = ((sel_bus.src == SRC_DEV)
		&& (sel_bus.sel >= SEL_DEV_RSVD))
		|| ((sel_bus.src[2:1] == 2'b11) && (sel_bus.sel > SEL_TX_IRQ));
	assign sel_bus.reserved = src_rsvd | sel_rsvd;
	assign sel_bus.level = !sel_bus.src[2] ? rx_level :
		(sel_bus.src == SRC_DEV) ? dev_level :
		src_rsvd ? 1'b0 : tx_level;
endmodule : pin_source_mux

// [logic/pin_output_source_mux.sv]
`timescale 1ns/1ps
// Behaviour
// - source code picks rx, status or tx
// - selection meaning depends on chosen source
// - rx selections 0-3 forward remote pins
// - rx selections 4-7 lock, pass, fv, lv
// - status group: value, lock or, pass and, sync
// - status selection 2 is lock and
// - tx selections: pass and/or, fv, lv, sync
// - tx selection 5 is tx interrupt
// - value bit drives pin in register mode
// - pin driven only while enable bit set
// - control register resets to zero
module pin_output_source_mux
	import pin_mux_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic [15:0] RX_REMOTE_PIN_I,
	input wire logic [3:0] RX_LOCK_I,
	input wire logic [3:0] RX_PASS_I,
	input wire logic [3:0] RX_FV_I,
	input wire logic [3:0] RX_LV_I,
	input wire logic [3:0] RX_PORT_EN_I,
	input wire logic FRAME_SYNC_SIGNAL_I,
	input wire logic [7:0] TX_RX_MASK_I,
	input wire logic [1:0] TX_FV_I,
	input wire logic [1:0] TX_LV_I,
	input wire logic [1:0] TX_SYNC_I,
	input wire logic [1:0] TX_IRQ_I,
	input wire logic PIN4_I,
	output logic PIN4_O,
	output logic PIN4_OE_O
);
	logic rst_meta_r;
	logic rst_n;
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic level_r;
	logic rsvd_r;
	logic pin_in_r;
	logic setup;
	logic access;
	logic hit_ctrl;
	logic hit_stat;
	logic mapped;
	logic wr_ctrl;
	logic [3:0] stat;
	logic [31:0] rd_word;
	pin_sel_if sel_bus ();

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	// async assert, release after two edges so no flop sees a runt
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// apb decode, zero wait states
	// ---------------------------------------------------------------
	assign setup = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I;
	assign hit_ctrl = (PADDR_I == CTRL_OFS);
	assign hit_stat = (PADDR_I == STAT_OFS);
	assign mapped = hit_ctrl | hit_stat;
	assign wr_ctrl = access & PWRITE_I & hit_ctrl;
	assign ctrl_nxt = wr_ctrl ? PWDATA_I[7:0] : ctrl_r;
	assign stat = {rsvd_r, pin_in_r, ctrl_r[EN_BIT], level_r};
	assign rd_word = hit_ctrl ? {24'h00_0000, ctrl_r} :
		hit_stat ? {28'h000_0000, stat} : RD_NONE;
	// read data is captured in setup so it comes from a flop in access
	assign prdata_nxt = (setup & ~PWRITE_I) ? rd_word : prdata_r;
	assign PRDATA_O = prdata_r;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = access & ~mapped;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RST;
			prdata_r <= RD_NONE;
			level_r <= 1'b0;
			rsvd_r <= 1'b0;
			pin_in_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			level_r <= sel_bus.level;
			rsvd_r <= sel_bus.reserved;
			pin_in_r <= PIN4_I;
		end
	end

	// ---------------------------------------------------------------
	// source selection and pin drive
	// ---------------------------------------------------------------
	assign sel_bus.src = ctrl_r[SRC_LSB +: 3];
	assign sel_bus.sel = ctrl_r[SEL_LSB +: 3];
	assign sel_bus.reg_level = ctrl_r[VAL_BIT];

	pin_source_mux u_mux (
		.sel_bus (sel_bus),
		.rx_remote_pin_i (RX_REMOTE_PIN_I),
		.rx_lock_i (RX_LOCK_I),
		.rx_pass_i (RX_PASS_I),
		.rx_fv_i (RX_FV_I),
		.rx_lv_i (RX_LV_I),
		.rx_port_en_i (RX_PORT_EN_I),
		.frame_sync_signal_i (FRAME_SYNC_SIGNAL_I),
		.tx_rx_mask_i (TX_RX_MASK_I),
		.tx_fv_i (TX_FV_I),
		.tx_lv_i (TX_LV_I),
		.tx_sync_i (TX_SYNC_I),
		.tx_irq_i (TX_IRQ_I)
	);

	// level lags a control write by one cycle; the enable does not
	assign PIN4_O = level_r;
	assign PIN4_OE_O = ctrl_r[EN_BIT];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!rst_n);

	logic [2:0] a_src;
	logic [2:0] a_sel;
	logic a_rx_pick;
	logic [3:0] a_tx_mask;
	assign a_src = ctrl_r[SRC_LSB +: 3];
	assign a_sel = ctrl_r[SEL_LSB +: 3];
	assign a_rx_pick = RX_REMOTE_PIN_I[{a_src[1:0], a_sel[1:0]}];
	assign a_tx_mask = TX_RX_MASK_I[4*a_src[0] +: 4];

	sequence ctrl_write_seq(logic b);
		PSEL_I && !PENABLE_I && PWRITE_I && hit_ctrl
		##1 PSEL_I && PENABLE_I && PWRITE_I && hit_ctrl && PWDATA_I[EN_BIT] == b;
	endsequence

	sequence ctrl_read_seq;
		PSEL_I && !PENABLE_I && !PWRITE_I && hit_ctrl && !wr_ctrl;
	endsequence

	a_rx_remote_pin: assert property (
		(!a_src[2] && !a_sel[2]) |=> level_r == $past(a_rx_pick))
		else $error("remote pin level not forwarded");
	a_rx_lock_lv: assert property (
		(!a_src[2] && a_sel == SEL_RX_LOCK)
		|=> level_r == $past(RX_LOCK_I[a_src[1:0]]))
		else $error("rx lock not forwarded");
	a_rx_pass_fwd: assert property (
		(!a_src[2] && a_sel == 3'h5)
		|=> level_r == $past(RX_PASS_I[a_src[1:0]]))
		else $error("rx pass not forwarded");
	a_rx_line_valid: assert property (
		(!a_src[2] && a_sel == SEL_RX_LV)
		|=> level_r == $past(RX_LV_I[a_src[1:0]]))
		else $error("rx line valid not forwarded");
	a_dev_reg_level: assert property (
		(a_src == SRC_DEV && a_sel == SEL_DEV_REG) ##1 $stable(ctrl_r)
		|-> level_r == ctrl_r[VAL_BIT])
		else $error("pin does not follow value bit");
	a_dev_lock_or: assert property (
		(a_src == SRC_DEV && a_sel == SEL_DEV_LOCK_OR)
		|=> level_r == $past(|(RX_LOCK_I & RX_PORT_EN_I)))
		else $error("lock or of enabled ports wrong");
	a_dev_lock_and: assert property (
		(a_src == SRC_DEV && a_sel == SEL_DEV_LOCK_AND && RX_PORT_EN_I != 4'h0)
		|=> level_r == $past(&(RX_LOCK_I | ~RX_PORT_EN_I)))
		else $error("lock and of enabled ports wrong");
	a_dev_fsync: assert property (
		(a_src == SRC_DEV && a_sel == SEL_DEV_FSYNC)
		|=> level_r == $past(FRAME_SYNC_SIGNAL_I))
		else $error("frame sync not forwarded");
	a_dev_pass_and: assert property (
		(a_src == SRC_DEV && a_sel == 3'h3 && RX_PORT_EN_I != 4'h0)
		|=> level_r == $past(&(RX_PASS_I | ~RX_PORT_EN_I)))
		else $error("pass and of enabled ports wrong");
	a_tx_pass_and: assert property (
		(a_src[2:1] == 2'b11 && a_sel == SEL_TX_PASS_AND && a_tx_mask != 4'h0)
		|=> level_r == $past(&(RX_PASS_I | ~a_tx_mask)))
		else $error("tx pass and wrong");
	a_tx_irq_out: assert property (
		(a_src[2:1] == 2'b11 && a_sel == SEL_TX_IRQ)
		|=> level_r == $past(TX_IRQ_I[a_src[0]]))
		else $error("tx interrupt not forwarded");
	a_tx_pass_or: assert property (
		(a_src[2:1] == 2'b11 && a_sel == 3'h1)
		|=> level_r == $past(|(RX_PASS_I & a_tx_mask)))
		else $error("tx pass or wrong");
	a_tx_sel_rsvd: assert property (
		(a_src[2:1] == 2'b11 && a_sel > SEL_TX_IRQ)
		|=> !level_r && rsvd_r)
		else $error("reserved tx selection not low");
	a_reserved_low: assert property (
		(a_src == SRC_RSVD || (a_src == SRC_DEV && a_sel >= SEL_DEV_RSVD))
		|=> !level_r && rsvd_r)
		else $error("reserved code does not drive low");
	a_drive_enable: assert property (
		ctrl_write_seq(1'b0) |=> !PIN4_OE_O ##1 (!PIN4_OE_O || wr_ctrl || $past(wr_ctrl)))
		else $error("pin driven after enable cleared");
	a_enable_on: assert property (
		ctrl_write_seq(1'b1) |=> PIN4_OE_O)
		else $error("pin not driven after enable set");
	a_read_back: assert property (
		ctrl_read_seq |=> PRDATA_O == {24'h00_0000, ctrl_r})
		else $error("control read back wrong");
	a_reset_value: assert property (@(posedge REF_CLK_I) disable iff (1'b0)
		$rose(rst_n) |-> ctrl_r == CTRL_RST && !PIN4_OE_O)
		else $error("control not zero after reset");
endmodule : pin_output_source_mux

// [dv/pin_partner.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far-side logic watching the pin wire
// ---------------------------------------------------------------
module pin_partner (
	input wire logic clk_i,
	input wire logic pin_o_i,
	input wire logic pin_oe_i,
	output logic pin_level_o
);
	// a released wire must not keep its last level, so it toggles
	logic last_r = 1'b0;
	always_ff @(posedge clk_i) begin
		last_r <= pin_level_o;
	end
	assign pin_level_o = pin_oe_i ? pin_o_i : ~last_r;
endmodule : pin_partner

// [dv/tb_pin_output_source_mux.sv]
`timescale 1ns/1ps
module tb_pin_output_source_mux;
	import pin_mux_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, d;
	logic pready, pslverr, pin_o, pin_oe, pin_i, e;
	logic [15:0] rem = 16'h0;
	logic [3:0] lock = 4'h0, pass = 4'h0, fv = 4'h0, lv = 4'h0;
	logic [3:0] rx_en = 4'h0;
	logic fsync = 1'b0;
	logic [7:0] mask = 8'h00;
	logic [1:0] tfv = 2'h0, tlv = 2'h0, tsync = 2'h0, tirq = 2'h0;
	int fail_count = 0, samples_checked = 0;
	logic [63:0] pats [4] = '{64'h0, '1, 64'h5a3c_96e1_c3a5_0f69,
		64'ha5c3_691e_3c5a_f096};
	always #20 clk = ~clk;
	pin_output_source_mux dut (.REF_CLK_I(clk), .NRST_I(nrst),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .RX_REMOTE_PIN_I(rem), .RX_LOCK_I(lock),
		.RX_PASS_I(pass), .RX_FV_I(fv), .RX_LV_I(lv), .RX_PORT_EN_I(rx_en),
		.FRAME_SYNC_SIGNAL_I(fsync), .TX_RX_MASK_I(mask), .TX_FV_I(tfv),
		.TX_LV_I(tlv), .TX_SYNC_I(tsync), .TX_IRQ_I(tirq), .PIN4_I(pin_i),
		.PIN4_O(pin_o), .PIN4_OE_O(pin_oe));
	pin_partner partner (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
		.pin_level_o(pin_i));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	// ---------------------------------------------------------------
	// reference of the selected level
	// ---------------------------------------------------------------
	function automatic logic exp_pin(input logic [7:0] c);
		logic [2:0] s, v;
		logic [3:0] m;
		int t;
		s = c[4:2];
		v = c[7:5];
		t = s[0];
		m = mask[4*t +: 4];
		if (s < 3'h4) return v < 3'h4 ? rem[4*s + v] :
			v == 3'h4 ? lock[s] : v == 3'h5 ? pass[s] :
			v == 3'h6 ? fv[s] : lv[s];
		if (s == 3'h4) case (v)
			3'h0: return c[1];
			3'h1: return |(lock & rx_en);
			3'h2: return rx_en != 0 && &(lock | ~rx_en);
			3'h3: return rx_en != 0 && &(pass | ~rx_en);
			3'h4: return fsync;
			default: return 1'b0;
		endcase
		if (s == 3'h5) return 1'b0;
		case (v)
			3'h0: return m != 0 && &(pass | ~m);
			3'h1: return |(pass & m);
			3'h2: return tfv[t];
			3'h3: return tlv[t];
			3'h4: return tsync[t];
			3'h5: return tirq[t];
			default: return 1'b0;
		endcase
	endfunction : exp_pin
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		check({31'h0, pin_oe}, 32'h0);
		apb(1'b0, CTRL_OFS, 32'h0, d, e);
		check(d, 32'h0);
		check({31'h0, e}, 32'h0);
		check({31'h0, pready}, 32'h1);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_codes();
		for (int c = 0; c < 256; c++) begin
			apb(1'b1, CTRL_OFS, {24'hffffff, 8'(c)}, d, e);
			apb(1'b0, CTRL_OFS, 32'h0, d, e);
			check(d, {24'h0, 8'(c)});
			for (int k = 0; k < 4; k++) begin
				{rem, lock, pass, fv, lv, rx_en, fsync, mask, tfv, tlv, tsync,
					tirq} <= pats[k][52:0];
				@(posedge clk);
				@(negedge clk);
				check({31'h0, pin_o}, {31'h0, exp_pin(8'(c))});
				check({31'h0, pin_oe}, {31'h0, c[0]});
				@(posedge clk);
			end
		end
		$display("t_codes done");
	endtask : t_codes
	task automatic t_status();
		apb(1'b1, CTRL_OFS, 32'h13, d, e);
		repeat (3) @(posedge clk);
		apb(1'b0, STAT_OFS, 32'h0, d, e);
		check(d, 32'h7);
		apb(1'b1, CTRL_OFS, 32'h15, d, e);
		repeat (3) @(posedge clk);
		apb(1'b0, STAT_OFS, 32'h0, d, e);
		check(d, 32'ha);
		$display("t_status done");
	endtask : t_status
	task automatic t_unmapped();
		apb(1'b1, 8'h20, 32'hff, d, e);
		check({31'h0, e}, 32'h1);
		apb(1'b0, 8'h20, 32'h0, d, e);
		check({31'h0, e}, 32'h1);
		check(d, 32'h0);
		apb(1'b0, CTRL_OFS, 32'h0, d, e);
		check(d, 32'h15);
		$display("t_unmapped done");
	endtask : t_unmapped
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	// ---------------------------------------------------------------
	// sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_codes();
		t_status();
		t_unmapped();
		finish_test();
	end
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		finish_test();
	end
endmodule : tb_pin_output_source_mux
